// ### verilog/tws_pkg.sv
// package for the two-wire control slave: address, limits and timing constants
// assumes nothing beyond a single system clock domain
package tws_pkg;

  // ----------------------------------------
  // bus address and register space
  // ----------------------------------------
  localparam logic [5:0] TWS_ADDR_HI = 6'h26; // upper six bits 100110
  localparam logic [7:0] TWS_MAX_REG = 8'hEE; // highest implemented register
  localparam logic [7:0] TWS_BASE_RST = 8'h00; // base address after reset
  localparam logic [7:0] TWS_DATA_RST = 8'h00; // register contents after reset

  // ----------------------------------------
  // bit counting and timing
  // ----------------------------------------
  localparam logic [3:0] TWS_BITS_BYTE = 4'h8; // bits in one byte
  localparam int TWS_CLK_NS = 25; // system clock period
  localparam int TWS_SYNC_NS = 50; // two-stage pin synchroniser delay
  localparam int TWS_SYNC_CYC = (TWS_SYNC_NS + TWS_CLK_NS - 1) / TWS_CLK_NS;

  // slave phases, one-hot
  typedef enum logic [5:0] {
    TWS_IDLE = 6'b000001,
    TWS_ADDR = 6'b000010,
    TWS_AACK = 6'b000100,
    TWS_WRX  = 6'b001000,
    TWS_WACK = 6'b010000,
    TWS_RTX  = 6'b100000
  } tws_state_e;

endpackage

// ### verilog/tws_sync.sv
// two flip-flop synchroniser for the bus pins
// assumes inputs asynchronous to clk; output is safe to read
`timescale 1ns/1ps
module tws_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // ----------------------------------------
  // synchroniser stages
  // ----------------------------------------
  // idle bus reads high, so reset to ones
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_reg <= '1;
      sync_out <= '1;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

// ### verilog/tws_slave.sv
// two-wire control slave with an internal 8-bit register file
// assumes scl/sda come from pins with external pull-ups; clk 40 MHz
`timescale 1ns/1ps

module tws_slave #(
  parameter int REG_COUNT = 239
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic addr_select_pin,
  output logic [7:0] base_addr,
  output logic busy
);

  // ----------------------------------------
  // pin synchronisation and edge finding
  // ----------------------------------------
  logic [1:0] pins_s;
  logic scl_d_reg;
  logic sda_d_reg;
  wire scl_s = pins_s[1];
  wire sda_s = pins_s[0];

  tws_sync #(.WIDTH(2)) u_sync (
    .clk(clk),
    .reset(reset),
    .async_in({scl_in, sda_in}),
    .sync_out(pins_s)
  );

  // delayed copies of synchronised lines for edge detection
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  wire scl_rise = scl_s & ~scl_d_reg;
  wire scl_fall = ~scl_s & scl_d_reg;
  wire start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  // ----------------------------------------
  // register file
  // ----------------------------------------
  logic [7:0] regs [REG_COUNT];

  // saturating address step
  function automatic logic [7:0] next_addr(input logic [7:0] a);
    next_addr = (a >= tws_pkg::TWS_MAX_REG) ? tws_pkg::TWS_MAX_REG : 8'(a + 8'h01);
  endfunction

  // ----------------------------------------
  // protocol state
  // ----------------------------------------
  tws_pkg::tws_state_e state_reg;
  logic [7:0] shift_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] base_reg;
  logic rw_reg;
  logic first_reg;   // next write byte is the base address
  logic ack_reg;     // pull sda low during this ack slot
  logic hold_reg;    // sda output value while driving data
  logic drive_reg;
  logic mack_reg;    // master acknowledged last read byte

  // own address with pin-selected low bit
  wire [6:0] own_addr = {tws_pkg::TWS_ADDR_HI, addr_select_pin};
  wire addr_match = (shift_reg[7:1] == own_addr);
  wire byte_done = (bit_cnt_reg == tws_pkg::TWS_BITS_BYTE);
  wire base_ok = (shift_reg <= tws_pkg::TWS_MAX_REG);
  wire [7:0] rd_data = regs[base_reg];

  // sampling of sda on scl rise, msb first
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      shift_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
    end else if (start_det) begin
      bit_cnt_reg <= 4'h0;
    end else if (scl_rise) begin
      if (byte_done) begin
        // ninth pulse is the ack slot: no shift, so the byte stays intact
        bit_cnt_reg <= 4'h9;
      end else begin
        shift_reg <= {shift_reg[6:0], sda_s};
        bit_cnt_reg <= 4'(bit_cnt_reg + 4'h1);
      end
    end else if (scl_fall && bit_cnt_reg == 4'h9) begin
      // ack slot over, next byte starts counting from zero
      bit_cnt_reg <= 4'h0;
    end
  end

  // main sequencer, acting on scl falling edges
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      // register file cleared so reads before writes are defined
      for (int i = 0; i < REG_COUNT; i++) begin
        regs[i] <= tws_pkg::TWS_DATA_RST;
      end
      state_reg <= tws_pkg::TWS_IDLE;
      base_reg <= tws_pkg::TWS_BASE_RST;
      rw_reg <= 1'b0;
      first_reg <= 1'b0;
      ack_reg <= 1'b0;
      drive_reg <= 1'b0;
      hold_reg <= 1'b1;
      mack_reg <= 1'b0;
    end else if (start_det) begin
      // start or repeated start both reopen addressing
      state_reg <= tws_pkg::TWS_ADDR;
      drive_reg <= 1'b0;
    end else if (stop_det) begin
      state_reg <= tws_pkg::TWS_IDLE;
      drive_reg <= 1'b0;
    end else if (scl_rise && state_reg == tws_pkg::TWS_RTX && byte_done) begin
      // master ack sampled in ninth slot
      mack_reg <= ~sda_s;
    end else if (scl_fall) begin
      // sda only updated while scl low
      unique case (state_reg)
        tws_pkg::TWS_IDLE: begin
          drive_reg <= 1'b0;
        end
        tws_pkg::TWS_ADDR: begin
          if (byte_done) begin
            rw_reg <= shift_reg[0];
            // ack on match; stay released otherwise
            ack_reg <= addr_match;
            drive_reg <= addr_match;
            hold_reg <= 1'b0;
            first_reg <= 1'b1;
            state_reg <= addr_match ? tws_pkg::TWS_AACK : tws_pkg::TWS_IDLE;
          end
        end
        tws_pkg::TWS_AACK: begin
          if (rw_reg) begin
            // read begins at base; msb first
            state_reg <= tws_pkg::TWS_RTX;
            drive_reg <= ~rd_data[7];
            hold_reg <= 1'b0;
          end else begin
            state_reg <= tws_pkg::TWS_WRX;
            drive_reg <= 1'b0;
          end
        end
        tws_pkg::TWS_WRX: begin
          if (byte_done) begin
            if (first_reg) begin
              ack_reg <= base_ok;
              if (base_ok) begin
                base_reg <= shift_reg;
              end
              first_reg <= 1'b0;
            end else begin
              regs[base_reg] <= shift_reg;
              base_reg <= next_addr(base_reg);
              ack_reg <= 1'b1;
            end
            drive_reg <= first_reg ? base_ok : 1'b1;
            state_reg <= tws_pkg::TWS_WACK;
          end
        end
        tws_pkg::TWS_WACK: begin
          // no ack leaves sda released and waits for stop
          drive_reg <= 1'b0;
          state_reg <= ack_reg ? tws_pkg::TWS_WRX : tws_pkg::TWS_IDLE;
        end
        tws_pkg::TWS_RTX: begin
          if (byte_done) begin
            // release sda for master ack slot
            drive_reg <= 1'b0;
            base_reg <= next_addr(base_reg);
            mack_reg <= 1'b1;
          end else if (bit_cnt_reg == 4'h9) begin
            // first bit of a following byte after master ack
            if (mack_reg) begin
              drive_reg <= ~rd_data[7];
            end else begin
              state_reg <= tws_pkg::TWS_IDLE;
              drive_reg <= 1'b0;
            end
          end else begin
            drive_reg <= ~rd_data[3'(4'h7 - bit_cnt_reg)];
          end
        end
        default: begin
          state_reg <= tws_pkg::TWS_IDLE;
          drive_reg <= 1'b0;
        end
      endcase
    end
  end

  // count runs 0..8 over the data bits and 9 through the ack slot; the
  // falling edge that closes the slot returns it to 0, so the sequencer sees
  // count 8 at the end of a byte and count 9 at the end of its ack slot

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // open drain: only pull low, never touch scl
  assign sda_out = 1'b0;
  assign sda_oe = drive_reg;
  assign base_addr = base_reg;
  assign busy = (state_reg != tws_pkg::TWS_IDLE);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_idle_release;
    @(posedge clk) disable iff (reset)
      state_reg == tws_pkg::TWS_IDLE |-> !sda_oe;
  endproperty
  a_idle_release: assert property (p_idle_release) else $error("sda driven in idle");

  property p_start_addr;
    @(posedge clk) disable iff (reset) start_det |=> state_reg == tws_pkg::TWS_ADDR;
  endproperty
  a_start_addr: assert property (p_start_addr) else $error("start not to address");

  property p_stop_idle;
    @(posedge clk) disable iff (reset) stop_det && !start_det |=> state_reg == tws_pkg::TWS_IDLE;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop not to idle");

  property p_ack_match;
    @(posedge clk) disable iff (reset)
      state_reg == tws_pkg::TWS_ADDR && scl_fall && byte_done && addr_match && !start_det
      && !stop_det |=> sda_oe && state_reg == tws_pkg::TWS_AACK;
  endproperty
  a_ack_match: assert property (p_ack_match) else $error("matched address not acked");

  property p_nack_miss;
    @(posedge clk) disable iff (reset)
      state_reg == tws_pkg::TWS_ADDR && scl_fall && byte_done && !addr_match && !start_det
      && !stop_det |=> !sda_oe;
  endproperty
  a_nack_miss: assert property (p_nack_miss) else $error("mismatch acked");

  property p_stable_high;
    @(posedge clk) disable iff (reset) scl_s && scl_d_reg |=> $stable(sda_oe);
  endproperty
  a_stable_high: assert property (p_stable_high) else $error("sda moved with scl high");

  property p_saturate;
    @(posedge clk) disable iff (reset) base_reg == tws_pkg::TWS_MAX_REG
      && !(scl_fall && state_reg == tws_pkg::TWS_WRX && first_reg) |=> base_reg == tws_pkg::TWS_MAX_REG;
  endproperty
  a_saturate: assert property (p_saturate) else $error("address passed maximum");

  property p_base_range;
    @(posedge clk) disable iff (reset) base_reg <= tws_pkg::TWS_MAX_REG;
  endproperty
  a_base_range: assert property (p_base_range) else $error("base out of range");

  property p_read_release;
    @(posedge clk) disable iff (reset)
      state_reg == tws_pkg::TWS_RTX && bit_cnt_reg == 4'h9 |-> !sda_oe;
  endproperty
  a_read_release: assert property (p_read_release) else $error("ack slot driven");

  property p_nack_end;
    @(posedge clk) disable iff (reset)
      state_reg == tws_pkg::TWS_RTX && scl_fall && bit_cnt_reg == 4'h9 && !mack_reg
      && !start_det && !stop_det |=> state_reg == tws_pkg::TWS_IDLE && !sda_oe;
  endproperty
  a_nack_end: assert property (p_nack_end) else $error("sent after master nack");

  property p_open_drain;
    @(posedge clk) disable iff (reset) sda_oe |-> sda_out == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("sda driven high");

  c_write: cover property (@(posedge clk) state_reg == tws_pkg::TWS_WACK ##1 state_reg == tws_pkg::TWS_WRX);
  c_refuse: cover property (@(posedge clk) state_reg == tws_pkg::TWS_WACK && !ack_reg);
  c_read: cover property (@(posedge clk) state_reg == tws_pkg::TWS_RTX);
  c_restart: cover property (@(posedge clk) busy && start_det);

endmodule

// ### tb/tws_master_model.sv
// two-wire bus master model driving the control slave from the host side
// assumes sda is the wired-and of all pull-down enables with a pull-up
`timescale 1ns/1ps
module tws_master_model (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_oe
);
  // ----------------------------------------
  // bus phases, 4 clk half period = 200 ns bit
  // ----------------------------------------
  // scl stands high outside frames, never free-running
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end

  // wait on the falling edge so the slave samples settled levels
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic start();
    scl = 1'b0;
    w(2);
    sda_oe = 1'b0;
    w(2);
    scl = 1'b1;
    w(4);
    sda_oe = 1'b1;
    w(4);
  endtask

  task automatic stop();
    scl = 1'b0;
    w(2);
    sda_oe = 1'b1;
    w(2);
    scl = 1'b1;
    w(4);
    sda_oe = 1'b0;
    w(4);
  endtask

  // sda moves only in the low phase
  task automatic bitx(input logic d, output logic q);
    scl = 1'b0;
    w(2);
    sda_oe = ~d;
    w(2);
    scl = 1'b1;
    w(4);
    q = sda;
  endtask

  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic q;
    for (int i = 7; i >= 0; i--) bitx(b[i], q);
    bitx(1'b1, q);
    ack = ~q;
  endtask

  // read byte, then own ack or nack
  task automatic rbyte(input logic ack_in, output logic [7:0] b, output logic slot);
    for (int i = 7; i >= 0; i--) bitx(1'b1, b[i]);
    bitx(~ack_in, slot);
  endtask
endmodule

// ### tb/tb_two_wire_control_slave.sv
// self-checking bench for the two-wire control slave
// assumes the master model in tb/ and a pull-up on sda; scl is driven directly by the master model
`timescale 1ns/1ps
module tb_two_wire_control_slave;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic pin = 1'b0;
  logic scl, m_oe, s_oe, s_out, busy, ack, slot;
  logic [7:0] base, rd;
  wire sda = ~(m_oe | s_oe);
  int fail_count = 0;
  int compares = 0;

  always #12.5 clk = ~clk;

  tws_slave u_tws_slave (.clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda),
    .sda_out(s_out), .sda_oe(s_oe), .addr_select_pin(pin), .base_addr(base), .busy(busy));
  tws_master_model u_tws_master_model (.clk(clk), .sda(sda), .scl(scl), .sda_oe(m_oe));

  // ----------------------------------------
  // shared helpers
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic wb(input logic [7:0] b, input logic exp);
    u_tws_master_model.wbyte(b, ack);
    check(ack, exp, "acknowledge");
  endtask

  // write address, base and data; stop at the end
  task automatic wrseq(input logic [7:0] b, input logic [7:0] d[$]);
    u_tws_master_model.start();
    wb(8'h9A, 1'b1);
    wb(b, 1'b1);
    foreach (d[i]) wb(d[i], 1'b1);
    u_tws_master_model.stop();
  endtask

  // set base by a write, repeated start, read with nack on the last byte
  task automatic rdseq(input logic [7:0] b, input logic [7:0] e[$]);
    u_tws_master_model.start();
    wb(8'h9A, 1'b1);
    wb(b, 1'b1);
    u_tws_master_model.start();
    wb(8'h9B, 1'b1);
    foreach (e[i]) begin
      u_tws_master_model.rbyte(i != e.size() - 1, rd, slot);
      check(rd, e[i], "read data");
    end
    check(slot, 1'b1, "ack slot released");
    u_tws_master_model.bitx(1'b1, slot);
    check(slot, 1'b1, "sending ended");
    u_tws_master_model.stop();
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // both select levels: own address acked, the twin address refused
  task automatic t_addr();
    for (int p = 0; p < 2; p++) begin
      pin = p[0];
      u_tws_master_model.start();
      wb({6'h26, p[0], 1'b0}, 1'b1);
      check(busy, 1'b1, "busy after start");
      check(s_out, 1'b0, "only pulls low");
      u_tws_master_model.stop();
      check(busy, 1'b0, "idle after stop");
      u_tws_master_model.start();
      wb({6'h26, ~p[0], 1'b0}, 1'b0);
      u_tws_master_model.stop();
    end
    $display("t_addr done");
  endtask

  task automatic t_burst();
    wrseq(8'h10, '{8'h11, 8'h22, 8'h33, 8'h44});
    rdseq(8'h10, '{8'h11, 8'h22, 8'h33, 8'h44});
    $display("t_burst done");
  endtask

  // top of the space: further bytes land on the last register
  task automatic t_sat();
    wrseq(8'hED, '{8'h5A, 8'hA5, 8'h3C});
    check(base, 8'hEE, "pointer saturated");
    rdseq(8'hED, '{8'h5A, 8'h3C, 8'h3C});
    $display("t_sat done");
  endtask

  task automatic t_bad();
    u_tws_master_model.start();
    wb(8'h9A, 1'b1);
    wb(8'hEF, 1'b0);
    check(sda, 1'b1, "sda left high");
    u_tws_master_model.stop();
    rdseq(8'h13, '{8'h44});
    $display("t_bad done");
  endtask

  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // watchdog, well beyond the roughly 70 us the tests need
  initial begin
    #2000000;
    fail_count++;
    wrap_up();
  end

  initial begin
    repeat (20) @(negedge clk);
    check(base, 8'h00, "base after reset");
    reset = 1'b0;
    repeat (4) @(negedge clk);
    t_addr();
    t_burst();
    t_sat();
    t_bad();
    wrap_up();
  end
endmodule
